/* rtl/pdp_pkg.sv */
/*
 Constants of the synthesizer digital core: register offsets, field layouts,
 reset values and timing counts. Assumes a single 200 MHz core clock.
*/
// Operation
// - Reference divider is a ten-bit counter dividing by 2 through 1023.
// - Reference divider counts reference input edges and feeds the detector reference side.
// - Comparison rate equals reference rate divided by the programmed reference ratio.
// - RF input passes a 32/33 prescaler whose output clocks the feedback counters.
// - Swallow counter is five bits, 0 to 31, counting divide-by-33 cycles.
// - Main feedback counter is ten bits, accepting values 3 to 1023.
// - Total feedback ratio equals 32 times main count plus swallow count.
// - Feedback ratios 992 through 32767 are all reachable without gaps.
// - Feedback divider output drives the detector feedback side.
// - Polarity bit swaps pump-up and pump-down outputs.
// - Detector resolves phase errors from minus two pi to plus two pi.
// - Pump-up sources charge toward supply; pump-down sinks toward ground.
// - Locked pump output is mostly high impedance, brief corrections per period.
// - Locked detector still emits both pump pulses at minimum width.
// - Serial bits arrive MSB first, shifted in on rising serial clock.
// - Serial shift register is eighteen bits, bit zero selects the target.
// - Rising load strobe copies shift register into reference or feedback register.
package pdp_pkg;
	localparam int          SHIFT_W       = 18;
	localparam int          FIELD_W       = 17;
	// Bus byte offsets
	localparam logic [7:0]  OFS_REF       = 8'h00;
	localparam logic [7:0]  OFS_FB        = 8'h04;
	localparam logic [7:0]  OFS_STATUS    = 8'h08;
	localparam logic [7:0]  OFS_SHIFT     = 8'h0c;
	// Reference register data field
	localparam int          REF_RATIO_LSB = 0;
	localparam int          REF_TRI_BIT   = 10;
	localparam int          REF_POL_BIT   = 11;
	// Feedback register data field
	localparam int          FB_PD_LSB     = 0;
	localparam int          FB_SWAL_LSB   = 2;
	localparam int          FB_MAIN_LSB   = 7;
	// Reset values of the data fields
	localparam logic [16:0] REF_RESET     = 17'h0080a;
	localparam logic [16:0] FB_RESET      = 17'h01f00;
	// Limits and modulus
	localparam logic [9:0]  REF_MIN       = 10'h002;
	localparam logic [9:0]  MAIN_MIN      = 10'h003;
	localparam logic [5:0]  PRE_LOW_LAST  = 6'h1f;
	localparam logic [5:0]  PRE_HIGH_LAST = 6'h20;
	// Timing
	localparam int          MCLK_PS       = 5000;
	localparam int          PUMP_MIN_PS   = 10000;
	localparam int          PUMP_MIN_CYC  = (PUMP_MIN_PS + MCLK_PS - 1) / MCLK_PS;
	localparam logic [3:0]  PUMP_MIN_LAST = 4'(PUMP_MIN_CYC - 1);
	typedef enum logic [1:0] {PDP_IDLE, PDP_UP, PDP_DN, PDP_BOTH} pdp_pfd_t;
endpackage

/* rtl/pdp_core.sv */
/*
 Synthesizer digital core: reference divider, 32/33 prescaler with swallow
 and main counters, phase/frequency detector, charge pump controls, serial
 programming port and a plain register port.
 Assumes reference, RF and serial inputs are synchronous to mclk and each
 high or low for at least one mclk cycle.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pdp_core (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        ref_in,
	input  wire logic        rf_in,
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        load_strobe,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rd_data,
	output logic             ref_div_out,
	output logic             fb_div_out,
	output logic             pump_up,
	output logic             pump_down,
	output logic             pump_output,
	output logic             pump_output_oe
);
	function automatic logic [9:0] floor_at(input logic [9:0] v, input logic [9:0] lo);
		floor_at = (v < lo) ? lo : v;
	endfunction

	// Edge detection of synchronous inputs
	logic ref_q, rf_q, sclk_q, ld_q;
	logic ref_rise, rf_rise, ser_rise, ld_rise;
	always_ff @(posedge mclk) begin
		if (reset) begin
			ref_q  <= 1'b0;
			rf_q   <= 1'b0;
			sclk_q <= 1'b0;
			ld_q   <= 1'b0;
		end else begin
			ref_q  <= ref_in;
			rf_q   <= rf_in;
			sclk_q <= ser_clk;
			ld_q   <= load_strobe;
		end
	end
	always_comb begin
		ref_rise = ref_in & ~ref_q;
		rf_rise  = rf_in & ~rf_q;
		ser_rise = ser_clk & ~sclk_q;
		ld_rise  = load_strobe & ~ld_q;
	end

	// Serial shift register and the two control latches
	logic [17:0] shift, next_shift;
	logic [16:0] ref_field, next_ref_field;
	logic [16:0] fb_field, next_fb_field;
	always_comb begin
		next_shift     = shift;
		next_ref_field = ref_field;
		next_fb_field  = fb_field;
		if (ser_rise)
			next_shift = {shift[16:0], ser_data};
		if (wr_en && addr == pdp_pkg::OFS_REF)
			next_ref_field = wr_data[16:0];
		if (wr_en && addr == pdp_pkg::OFS_FB)
			next_fb_field = wr_data[16:0];
		// Serial load is applied last so it wins a same-cycle bus write
		if (ld_rise) begin
			if (shift[0])
				next_ref_field = shift[17:1];
			else
				next_fb_field = shift[17:1];
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			shift     <= '0;
			ref_field <= pdp_pkg::REF_RESET;
			fb_field  <= pdp_pkg::FB_RESET;
		end else begin
			shift     <= next_shift;
			ref_field <= next_ref_field;
			fb_field  <= next_fb_field;
		end
	end

	logic [9:0] ref_ratio, main_ratio;
	logic [4:0] swallow_count;
	logic       pump_tristate, detector_polarity, cnt_hold;
	always_comb begin
		ref_ratio         = floor_at(ref_field[pdp_pkg::REF_RATIO_LSB +: 10], pdp_pkg::REF_MIN);
		pump_tristate     = ref_field[pdp_pkg::REF_TRI_BIT];
		detector_polarity = ref_field[pdp_pkg::REF_POL_BIT];
		swallow_count     = fb_field[pdp_pkg::FB_SWAL_LSB +: 5];
		main_ratio        = floor_at(fb_field[pdp_pkg::FB_MAIN_LSB +: 10], pdp_pkg::MAIN_MIN);
		// Any non-zero power-down code holds both dividers at their load point
		cnt_hold          = fb_field[pdp_pkg::FB_PD_LSB +: 2] != 2'b00;
	end

	// Reference divider
	logic [9:0] r_left, next_r_left;
	logic       next_ref_div_out;
	always_comb begin
		next_r_left      = r_left;
		next_ref_div_out = 1'b0;
		if (cnt_hold) begin
			next_r_left = ref_ratio;
		end else if (ref_rise) begin
			if (r_left <= 10'h001) begin
				next_r_left      = ref_ratio;
				next_ref_div_out = 1'b1;
			end else begin
				next_r_left = r_left - 10'h001;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			r_left      <= pdp_pkg::REF_MIN;
			ref_div_out <= 1'b0;
		end else begin
			r_left      <= next_r_left;
			ref_div_out <= next_ref_div_out;
		end
	end

	// Prescaler with swallow and main counters: 33*A + 32*(B-A) = 32*B + A
	logic [5:0] pre_cnt, next_pre_cnt, pre_last;
	logic [4:0] a_left, next_a_left;
	logic [9:0] b_left, next_b_left;
	logic       next_fb_div_out;
	always_comb begin
		next_pre_cnt    = pre_cnt;
		next_a_left     = a_left;
		next_b_left     = b_left;
		next_fb_div_out = 1'b0;
		pre_last = (a_left != 5'h00) ? pdp_pkg::PRE_HIGH_LAST : pdp_pkg::PRE_LOW_LAST;
		if (cnt_hold) begin
			next_pre_cnt = '0;
			next_a_left  = swallow_count;
			next_b_left  = main_ratio;
		end else if (rf_rise) begin
			if (pre_cnt >= pre_last) begin
				next_pre_cnt = '0;
				if (a_left != 5'h00)
					next_a_left = a_left - 5'h01;
				if (b_left <= 10'h001) begin
					next_b_left     = main_ratio;
					next_a_left     = swallow_count;
					next_fb_div_out = 1'b1;
				end else begin
					next_b_left = b_left - 10'h001;
				end
			end else begin
				next_pre_cnt = pre_cnt + 6'h01;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_cnt    <= '0;
			a_left     <= '0;
			b_left     <= pdp_pkg::MAIN_MIN;
			fb_div_out <= 1'b0;
		end else begin
			pre_cnt    <= next_pre_cnt;
			a_left     <= next_a_left;
			b_left     <= next_b_left;
			fb_div_out <= next_fb_div_out;
		end
	end

	// Phase/frequency detector: a four-state machine plus a reset delay
	// that sets the minimum width of both pulses when locked
	pdp_pkg::pdp_pfd_t pfd, next_pfd;
	logic [3:0] rst_cnt, next_rst_cnt;
	logic       up_raw, dn_raw;
	logic       next_pump_up, next_pump_down, next_pump_output, next_pump_output_oe;
	always_comb begin
		next_pfd     = pfd;
		next_rst_cnt = 4'h0;
		case (pfd)
			pdp_pkg::PDP_IDLE: begin
				if (ref_div_out && fb_div_out)
					next_pfd = pdp_pkg::PDP_BOTH;
				else if (ref_div_out)
					next_pfd = pdp_pkg::PDP_UP;
				else if (fb_div_out)
					next_pfd = pdp_pkg::PDP_DN;
			end
			pdp_pkg::PDP_UP: begin
				if (fb_div_out)
					next_pfd = pdp_pkg::PDP_BOTH;
			end
			pdp_pkg::PDP_DN: begin
				if (ref_div_out)
					next_pfd = pdp_pkg::PDP_BOTH;
			end
			pdp_pkg::PDP_BOTH: begin
				next_rst_cnt = rst_cnt + 4'h1;
				if (rst_cnt >= pdp_pkg::PUMP_MIN_LAST) begin
					next_rst_cnt = 4'h0;
					// A new edge in the clearing cycle is kept, not lost
					if (ref_div_out && fb_div_out)
						next_pfd = pdp_pkg::PDP_BOTH;
					else if (ref_div_out)
						next_pfd = pdp_pkg::PDP_UP;
					else if (fb_div_out)
						next_pfd = pdp_pkg::PDP_DN;
					else
						next_pfd = pdp_pkg::PDP_IDLE;
				end
			end
			default: next_pfd = pdp_pkg::PDP_IDLE;
		endcase
		up_raw = next_pfd == pdp_pkg::PDP_UP || next_pfd == pdp_pkg::PDP_BOTH;
		dn_raw = next_pfd == pdp_pkg::PDP_DN || next_pfd == pdp_pkg::PDP_BOTH;
		next_pump_up   = detector_polarity ? up_raw : dn_raw;
		next_pump_down = detector_polarity ? dn_raw : up_raw;
		// With pump_tristate clear, source when up alone and sink when down alone; float otherwise
		next_pump_output    = next_pump_up;
		next_pump_output_oe = (next_pump_up ^ next_pump_down) & ~pump_tristate;
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			pfd            <= pdp_pkg::PDP_IDLE;
			rst_cnt        <= 4'h0;
			pump_up        <= 1'b0;
			pump_down      <= 1'b0;
			pump_output    <= 1'b0;
			pump_output_oe <= 1'b0;
		end else begin
			pfd            <= next_pfd;
			rst_cnt        <= next_rst_cnt;
			pump_up        <= next_pump_up;
			pump_down      <= next_pump_down;
			pump_output    <= next_pump_output;
			pump_output_oe <= next_pump_output_oe;
		end
	end

	// Register read port, data one cycle after the strobe
	logic [31:0] next_rd_data;
	always_comb begin
		next_rd_data = '0;
		if (rd_en) begin
			case (addr)
				pdp_pkg::OFS_REF:    next_rd_data = {15'h0000, ref_field};
				pdp_pkg::OFS_FB:     next_rd_data = {15'h0000, fb_field};
				pdp_pkg::OFS_STATUS: next_rd_data = {24'h000000, pfd, pump_up, pump_down, pump_output_oe,
					ref_div_out, fb_div_out, cnt_hold};
				pdp_pkg::OFS_SHIFT:  next_rd_data = {14'h0000, shift};
				default:             next_rd_data = '0;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (reset)
			rd_data <= '0;
		else
			rd_data <= next_rd_data;
	end

	// Checks
	ser_shift_a: assert property (@(posedge mclk) disable iff (reset)
		ser_rise |=> shift[0] == $past(ser_data) && shift[17:1] == $past(shift[16:0]))
		else $error("serial bit not shifted in");
	ser_load_a: assert property (@(posedge mclk) disable iff (reset)
		ld_rise && shift[0] |=> ref_field == $past(shift[17:1]))
		else $error("reference latch not loaded");
	ref_reload_a: assert property (@(posedge mclk) disable iff (reset)
		ref_div_out |-> r_left == $past(ref_ratio) && r_left >= pdp_pkg::REF_MIN)
		else $error("reference divider did not reload");
	pre_mod_a: assert property (@(posedge mclk) disable iff (reset || cnt_hold)
		a_left == 5'h00 && rf_rise && pre_cnt == 6'h1f |=> pre_cnt == 6'h00)
		else $error("prescaler did not wrap at 32");
	fb_reload_a: assert property (@(posedge mclk) disable iff (reset)
		fb_div_out |-> b_left == $past(main_ratio) && a_left == $past(swallow_count))
		else $error("feedback counters did not reload");
	pfd_up_a: assert property (@(posedge mclk) disable iff (reset)
		ref_div_out && !fb_div_out && pfd == pdp_pkg::PDP_IDLE |=> pfd == pdp_pkg::PDP_UP)
		else $error("reference edge did not raise up");
	pump_width_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(pump_up && pump_down) |-> (pump_up && pump_down)[*2])
		else $error("locked pulses too short");
	pump_swap_a: assert property (@(posedge mclk) disable iff (reset)
		##1 $past(detector_polarity) == 1'b0 |-> pump_up == (pfd == pdp_pkg::PDP_DN || pfd == pdp_pkg::PDP_BOTH))
		else $error("polarity swap not applied");
	pump_float_a: assert property (@(posedge mclk) disable iff (reset)
		pump_up && pump_down |-> !pump_output_oe)
		else $error("pump driven while both commands active");
	pfd_clear_a: assert property (@(posedge mclk) disable iff (reset)
		pfd == pdp_pkg::PDP_BOTH && rst_cnt == 4'h1 && !ref_div_out && !fb_div_out |=> pfd == pdp_pkg::PDP_IDLE)
		else $error("detector did not clear");

	// Pump mapping, counter steps and detector transitions
	pol_up_map_a: assert property (@(posedge mclk) disable iff (reset)
		$past(detector_polarity) |-> pump_up == (pfd == pdp_pkg::PDP_UP || pfd == pdp_pkg::PDP_BOTH))
		else $error("pump up not mapped from detector up");
	pol_down_map_a: assert property (@(posedge mclk) disable iff (reset)
		$past(detector_polarity) |-> pump_down == (pfd == pdp_pkg::PDP_DN || pfd == pdp_pkg::PDP_BOTH))
		else $error("pump down not mapped from detector down");
	pump_source_a: assert property (@(posedge mclk) disable iff (reset)
		pump_output_oe && pump_up |-> pump_output)
		else $error("pump up does not source");
	pump_sink_a: assert property (@(posedge mclk) disable iff (reset)
		pump_output_oe && pump_down |-> !pump_output)
		else $error("pump down does not sink");
	pump_tri_a: assert property (@(posedge mclk) disable iff (reset)
		$past(pump_tristate) |-> !pump_output_oe)
		else $error("pump driven while forced to float");
	fb_load_a: assert property (@(posedge mclk) disable iff (reset)
		ld_rise && !shift[0] |=> fb_field == $past(shift[17:1]))
		else $error("feedback latch not loaded");
	shift_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!ser_rise |=> shift == $past(shift))
		else $error("shift register moved without serial clock");
	ref_count_a: assert property (@(posedge mclk) disable iff (reset)
		ref_rise && !cnt_hold && r_left > 10'h001 |=> r_left == $past(r_left) - 10'h001)
		else $error("reference divider did not count down");
	swal_mod_a: assert property (@(posedge mclk) disable iff (reset)
		!cnt_hold && a_left != 5'h00 && rf_rise && pre_cnt == 6'h1f |=> pre_cnt == 6'h20)
		else $error("prescaler did not extend to 33");
	hold_quiet_a: assert property (@(posedge mclk) disable iff (reset)
		cnt_hold |=> !ref_div_out && !fb_div_out)
		else $error("divider pulsed while held");
	ref_gap_a: assert property (@(posedge mclk) disable iff (reset)
		ref_div_out |=> !ref_div_out)
		else $error("reference pulse longer than one cycle");
	fb_gap_a: assert property (@(posedge mclk) disable iff (reset)
		fb_div_out |=> !fb_div_out)
		else $error("feedback pulse longer than one cycle");
	pfd_down_a: assert property (@(posedge mclk) disable iff (reset)
		fb_div_out && !ref_div_out && pfd == pdp_pkg::PDP_IDLE |=> pfd == pdp_pkg::PDP_DN)
		else $error("feedback edge did not raise down");
	pfd_both_a: assert property (@(posedge mclk) disable iff (reset)
		pfd == pdp_pkg::PDP_UP && fb_div_out |=> pfd == pdp_pkg::PDP_BOTH)
		else $error("detector missed the late feedback edge");
endmodule

/* test/pdp_source_model.sv */
/*
 Reference oscillator and VCO stand-ins driving the synthesizer core.
 Assumes mclk is the core clock; both outputs change just after its rising edge.
*/
`timescale 1ns/1ps
module pdp_source_model (
	input  wire logic       mclk,
	input  wire logic       ref_run,
	input  wire logic       rf_run,
	input  wire logic [3:0] ref_half,
	output logic            ref_in,
	output logic            rf_in
);
	logic [3:0] ref_cnt = 4'h0;
	initial ref_in = 1'b0;
	initial rf_in = 1'b0;
	// A stopped source sits low, as a gated oscillator would
	always @(posedge mclk) begin
		if (ref_run && ref_cnt + 4'h1 >= ref_half) begin
			ref_cnt <= 4'h0;
			ref_in  <= ~ref_in;
		end else begin
			ref_cnt <= ref_run ? ref_cnt + 4'h1 : 4'h0;
			ref_in  <= ref_run ? ref_in : 1'b0;
		end
		rf_in <= rf_run ? ~rf_in : 1'b0;
	end
endmodule

/* test/tb_pdp_core.sv */
/*
 Self-checking bench for the synthesizer core.
 Assumes the source model for reference and RF inputs; the bench is the serial and bus host.
*/
`timescale 1ns/1ps
module tb_pdp_core;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        ser_clk = 1'b0;
	logic        ser_data = 1'b0;
	logic        load_strobe = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        rd_d = 1'b0;
	logic        ref_run = 1'b0;
	logic        rf_run = 1'b0;
	logic [3:0]  ref_half = 4'h5;
	logic        ref_in, rf_in, ref_div_out, fb_div_out;
	logic        pump_up, pump_down, pump_output, pump_output_oe;
	logic [31:0] rd_data;
	logic [31:0] exp_q[$];
	int          num_errors = 0;
	int          comparisons = 0;
	int          n;
	int          n_idle;
	logic [9:0]  r;
	logic [4:0]  s;

	always #2.5 mclk = ~mclk;

	pdp_source_model src (.mclk(mclk), .ref_run(ref_run), .rf_run(rf_run), .ref_half(ref_half),
		.ref_in(ref_in), .rf_in(rf_in));
	pdp_core dut (.mclk(mclk), .reset(reset), .ref_in(ref_in), .rf_in(rf_in), .ser_clk(ser_clk),
		.ser_data(ser_data), .load_strobe(load_strobe), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .ref_div_out(ref_div_out), .fb_div_out(fb_div_out),
		.pump_up(pump_up), .pump_down(pump_down), .pump_output(pump_output),
		.pump_output_oe(pump_output_oe));

	task automatic give_verdict();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_d)
			check(rd_data, exp_q.pop_front());
		rd_d <= rd_en;
	end

	task automatic wr(input logic [7:0] a, input logic [16:0] f);
		addr    <= a;
		wr_data <= {15'h0, f};
		wr_en   <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		// Idle cycle so a following call never reassigns a strobe in this step
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [16:0] f);
		addr  <= a;
		rd_en <= 1'b1;
		exp_q.push_back({15'h0, f});
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
	endtask

	// Idle data line shows the inverse of the last bit, not a held value
	task automatic ser_load(input logic [16:0] f, input logic a);
		logic [17:0] w;
		w = {f, a};
		for (int i = 17; i >= 0; i--) begin
			ser_data <= w[i];
			@(posedge mclk);
			ser_clk <= 1'b1;
			@(posedge mclk);
			ser_clk <= 1'b0;
		end
		ser_data    <= ~w[0];
		load_strobe <= 1'b1;
		@(posedge mclk);
		load_strobe <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	function automatic logic pulse(input bit fb);
		return fb ? fb_div_out : ref_div_out;
	endfunction

	// Third interval only: the first reload after a write may still use the old ratio
	task automatic span(input bit fb, input int exp_n);
		int c;
		c = 0;
		for (int k = 0; k < 3; k++) begin
			c = 0;
			do begin
				@(posedge mclk);
				c++;
			end while (pulse(fb) !== 1'b1 && c < 12000);
		end
		check(32'(c), 32'(exp_n));
	endtask

	task automatic pchk(input logic [16:0] f, input logic [3:0] e, input logic [3:0] m);
		wr(pdp_pkg::OFS_REF, f);
		span(1'b0, 20);
		repeat (2) @(posedge mclk);
		check(32'({pump_up, pump_down, pump_output, pump_output_oe} & m), 32'(e));
	endtask

	initial begin
		repeat (90000) @(posedge mclk);
		num_errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(32'h81032b3a));
		r = 10'(2 + $urandom % 8);
		s = 5'($urandom % 4);
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(pdp_pkg::OFS_REF, pdp_pkg::REF_RESET);
		rd(pdp_pkg::OFS_FB, pdp_pkg::FB_RESET);
		rd(8'h10, 17'h0);
		ser_load({5'h0, 2'b10, r}, 1'b1);
		rd(pdp_pkg::OFS_REF, {5'h0, 2'b10, r});
		ser_load({10'd3, s, 2'b00}, 1'b0);
		rd(pdp_pkg::OFS_FB, {10'd3, s, 2'b00});
		ref_run <= 1'b1;
		rf_run  <= 1'b1;
		span(1'b0, 10 * int'(r));
		span(1'b1, 2 * (96 + int'(s)));
		wr(pdp_pkg::OFS_REF, {5'h0, 2'b10, 10'd1023});
		span(1'b0, 10230);
		wr(pdp_pkg::OFS_FB, {10'd31, 5'd31, 2'b00});
		span(1'b1, 2046);
		rf_run <= 1'b0;
		pchk({5'h0, 2'b11, 10'd2}, 4'b1000, 4'b1101);
		pchk({5'h0, 2'b00, 10'd2}, 4'b0101, 4'b1111);
		pchk({5'h0, 2'b10, 10'd2}, 4'b1011, 4'b1111);
		ref_run <= 1'b0;
		rf_run  <= 1'b1;
		span(1'b1, 2046);
		// Mid-run reset clears the detector, then both dividers leave the hold point together
		ref_run <= 1'b1;
		reset   <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		wr(pdp_pkg::OFS_FB, {10'd4, 5'd2, 2'b01});
		rd(pdp_pkg::OFS_REF, pdp_pkg::REF_RESET);
		wr(pdp_pkg::OFS_REF, {5'h0, 2'b10, 10'd26});
		repeat (20) @(posedge mclk);
		wr(pdp_pkg::OFS_FB, {10'd4, 5'd2, 2'b00});
		// Equal 260-cycle periods: any 260-cycle window holds one full comparison
		span(1'b1, 260);
		n      = 0;
		n_idle = 0;
		for (int k = 0; k < 260; k++) begin
			@(posedge mclk);
			if (pump_up === 1'b1 && pump_down === 1'b1)
				n++;
			if (pump_up === 1'b0 && pump_down === 1'b0)
				n_idle++;
		end
		check(32'(n), 32'h2);
		check(32'(n_idle >= 240), 32'h1);
		give_verdict();
	end
endmodule
